/* File: hdl/qcs_pkg.sv */
/*
 * Constants shared by the quadrature count source select block:
 * register offsets, field layout, reset values and mode presets.
 * Assumes a 32-bit classic Wishbone register bus and byte addressing.
 */
package qcs_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_MODE   = 8'h04;
  localparam logic [7:0] OFS_START  = 8'h08;
  localparam logic [7:0] OFS_STOP   = 8'h0c;
  localparam logic [7:0] OFS_CLEAR  = 8'h10;
  localparam logic [7:0] OFS_UP     = 8'h14;
  localparam logic [7:0] OFS_DOWN   = 8'h18;
  localparam logic [7:0] OFS_COUNT  = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // ==========================================================
  // source set layout: [7:0] phase conditions, [15:8] trigger edges
  localparam int SRC_W   = 16;
  localparam int PH_W    = 8;
  localparam int TRG_W   = 8;
  localparam int CNT_W   = 32;
  localparam int NIN     = 6;  // phase a, phase b, triggers a..d
  localparam int MODE_W  = 3;

  // ctrl fields
  localparam int CTRL_START_BIT = 0;  // write 1: start counting
  localparam int CTRL_STOP_BIT  = 1;  // write 1: stop counting
  localparam int CTRL_CLEAR_BIT = 2;  // write 1: clear counter

  // status fields
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_DIR_BIT = 1;

  // ==========================================================
  // mode codes
  localparam logic [MODE_W-1:0] MODE_CUSTOM = 3'h0;
  localparam logic [MODE_W-1:0] MODE_1      = 3'h1;
  localparam logic [MODE_W-1:0] MODE_2_1    = 3'h2;
  localparam logic [MODE_W-1:0] MODE_2_2    = 3'h3;
  localparam logic [MODE_W-1:0] MODE_2_3    = 3'h4;
  localparam logic [MODE_W-1:0] MODE_3_1    = 3'h5;
  localparam logic [MODE_W-1:0] MODE_3_2    = 3'h6;

  // phase condition presets; bit order:
  // 0 a rise b0, 1 a rise b1, 2 a fall b0, 3 a fall b1,
  // 4 b rise a0, 5 b rise a1, 6 b fall a0, 7 b fall a1
  localparam logic [PH_W-1:0] UP_M1    = 8'h69;
  localparam logic [PH_W-1:0] DN_M1    = 8'h96;
  localparam logic [PH_W-1:0] UP_M2_1  = 8'h08;
  localparam logic [PH_W-1:0] DN_M2_1  = 8'h04;
  localparam logic [PH_W-1:0] UP_M2_2  = 8'h02;
  localparam logic [PH_W-1:0] DN_M2_2  = 8'h01;
  localparam logic [PH_W-1:0] UP_M2_3  = 8'h0a;
  localparam logic [PH_W-1:0] DN_M2_3  = 8'h05;
  localparam logic [PH_W-1:0] UP_M3_1  = 8'h08;
  localparam logic [PH_W-1:0] DN_M3_1  = 8'h80;
  localparam logic [PH_W-1:0] UP_M3_2  = 8'h02;
  localparam logic [PH_W-1:0] DN_M3_2  = 8'h20;

  // ==========================================================
  // reset values
  localparam logic [SRC_W-1:0]  SRC_RST   = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_RST   = 32'h0000_0000;
  localparam logic [MODE_W-1:0] MODE_RST  = 3'h0;

endpackage

/* File: hdl/qcs_edge.sv */
/*
 * Input conditioner: two-stage synchroniser per input, then a
 * third stage for edge detection.
 * Assumes inputs may be asynchronous to clk_i.
 */
`timescale 1ns/1ps

module qcs_edge (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic [qcs_pkg::NIN-1:0] raw_i,
  output logic      [qcs_pkg::NIN-1:0] lvl_o,
  output logic      [qcs_pkg::NIN-1:0] rise_o,
  output logic      [qcs_pkg::NIN-1:0] fall_o
);

  // ==========================================================
  // per-input synchroniser and edge stage
  logic [qcs_pkg::NIN-1:0] meta_r;
  logic [qcs_pkg::NIN-1:0] sync_r;
  logic [qcs_pkg::NIN-1:0] prev_r;

  genvar gi;
  generate
    for (gi = 0; gi < qcs_pkg::NIN; gi++) begin : g_in
      // meta stage feeds only the sync stage
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
          prev_r[gi] <= 1'b0;
        end else begin
          meta_r[gi] <= raw_i[gi];
          sync_r[gi] <= meta_r[gi];
          prev_r[gi] <= sync_r[gi];
        end
      end
      assign rise_o[gi] = sync_r[gi] & ~prev_r[gi];
      assign fall_o[gi] = ~sync_r[gi] & prev_r[gi];
    end
  endgenerate

  // level seen before the current edge
  assign lvl_o = prev_r;

endmodule

/* File: hdl/qcs_top.sv */
/*
 * Quadrature count source select with 32-bit up/down counter and
 * classic Wishbone register slave.
 * Assumes one clock (200 MHz), synchronous active-high reset, and a
 * single-cycle classic Wishbone master.
 */
// Local design decisions: the Wishbone register port and the register offsets.
// How it works
// - Mode 1 up: a rise with b low, a fall with b high, b rise with a high, b fall with a low.
// - Mode 1 down: a rise with b high, a fall with b low, b rise with a low, b fall with a high.
// - In mode 2-1 only a falling edge of phase a with b high counts up.
// - In mode 2-1 only a falling edge of phase a with b low counts down.
// - In mode 2-2 only a rising edge of phase a with b high counts up.
// - In mode 2-2 only a rising edge of phase a with b low counts down.
// - In mode 2-3 both edges of phase a with b high count up.
// - In mode 2-3 both edges of phase a with b low count down.
// - In mode 3-1 only a falling edge of phase a with b high counts up.
// - In mode 3-1 only a falling edge of phase b with a high counts down.
// - In mode 3-2 only a rising edge of phase a with b high counts up.
// - In mode 3-2 only a rising edge of phase b with a high counts down.
// - External trigger edges never act as up or down count sources.
// - Start, stop, clear, up and down each have their own per-edge enable set.
// - The counter is an independent 32-bit up/down counter.
`timescale 1ns/1ps

module qcs_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // encoder and triggers
  input  wire logic        phase_a_input_i,
  input  wire logic        phase_b_input_i,
  input  wire logic        ext_trigger_a_i,
  input  wire logic        ext_trigger_b_i,
  input  wire logic        ext_trigger_c_i,
  input  wire logic        ext_trigger_d_i,
  // status
  output logic      [31:0] count_o,
  output logic             running_o,
  output logic             dir_down_o
);

  // ==========================================================
  // state
  typedef enum logic [1:0] {
    QCS_IDLE = 2'b01,
    QCS_RUN  = 2'b10
  } qcs_state_t;

  qcs_state_t                      state_r;
  qcs_state_t                      state_nxt;
  logic [qcs_pkg::MODE_W-1:0]      mode_r;
  logic [qcs_pkg::SRC_W-1:0]       start_src_r;
  logic [qcs_pkg::SRC_W-1:0]       stop_src_r;
  logic [qcs_pkg::SRC_W-1:0]       clear_src_r;
  logic [qcs_pkg::PH_W-1:0]        up_src_r;
  logic [qcs_pkg::PH_W-1:0]        dn_src_r;
  logic [qcs_pkg::CNT_W-1:0]       cnt_r;
  logic [qcs_pkg::CNT_W-1:0]       cnt_nxt;
  logic                            dir_r;
  logic [31:0]                     rdat_r;
  logic                            ack_r;

  // ==========================================================
  // input conditioning
  logic [qcs_pkg::NIN-1:0] lvl;
  logic [qcs_pkg::NIN-1:0] rise;
  logic [qcs_pkg::NIN-1:0] fall;
  logic [qcs_pkg::NIN-1:0] raw;

  assign raw = {ext_trigger_d_i, ext_trigger_c_i, ext_trigger_b_i,
                ext_trigger_a_i, phase_b_input_i, phase_a_input_i};

  qcs_edge u_edge (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .raw_i  (raw),
    .lvl_o  (lvl),
    .rise_o (rise),
    .fall_o (fall)
  );

  // ==========================================================
  // edge conditions
  wire a_lvl = lvl[0];
  wire b_lvl = lvl[1];
  wire [qcs_pkg::PH_W-1:0] ph_ev;
  wire [qcs_pkg::TRG_W-1:0] trg_ev;

  assign ph_ev[0] = rise[0] & ~b_lvl;
  assign ph_ev[1] = rise[0] &  b_lvl;
  assign ph_ev[2] = fall[0] & ~b_lvl;
  assign ph_ev[3] = fall[0] &  b_lvl;
  assign ph_ev[4] = rise[1] & ~a_lvl;
  assign ph_ev[5] = rise[1] &  a_lvl;
  assign ph_ev[6] = fall[1] & ~a_lvl;
  assign ph_ev[7] = fall[1] &  a_lvl;

  // trigger edges: rise/fall pairs for a..d
  assign trg_ev = {fall[5], rise[5], fall[4], rise[4],
                   fall[3], rise[3], fall[2], rise[2]};

  wire [qcs_pkg::SRC_W-1:0] all_ev = {trg_ev, ph_ev};

  wire start_hit = |(all_ev & start_src_r);
  wire stop_hit  = |(all_ev & stop_src_r);
  wire clear_hit = |(all_ev & clear_src_r);
  // up/down sets hold phase bits only
  wire up_hit    = |(ph_ev & up_src_r);
  wire dn_hit    = |(ph_ev & dn_src_r);

  // ==========================================================
  // bus decode
  wire        req     = wb_cyc_i & wb_stb_i & ~ack_r;
  wire        wr      = req & wb_we_i;
  wire [31:0] bmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire        wr_ctrl = wr & (wb_adr_i == qcs_pkg::OFS_CTRL);
  wire        wr_mode = wr & (wb_adr_i == qcs_pkg::OFS_MODE) & wb_sel_i[0];
  wire        wr_strt = wr & (wb_adr_i == qcs_pkg::OFS_START);
  wire        wr_stop = wr & (wb_adr_i == qcs_pkg::OFS_STOP);
  wire        wr_clr  = wr & (wb_adr_i == qcs_pkg::OFS_CLEAR);
  wire        wr_up   = wr & (wb_adr_i == qcs_pkg::OFS_UP);
  wire        wr_dn   = wr & (wb_adr_i == qcs_pkg::OFS_DOWN);
  wire        wr_cnt  = wr & (wb_adr_i == qcs_pkg::OFS_COUNT);

  wire sw_start = wr_ctrl & wb_sel_i[0] & wb_dat_i[qcs_pkg::CTRL_START_BIT];
  wire sw_stop  = wr_ctrl & wb_sel_i[0] & wb_dat_i[qcs_pkg::CTRL_STOP_BIT];
  wire sw_clear = wr_ctrl & wb_sel_i[0] & wb_dat_i[qcs_pkg::CTRL_CLEAR_BIT];

  // masked merge helpers
  wire [qcs_pkg::SRC_W-1:0] wmask16 = bmask[qcs_pkg::SRC_W-1:0];
  wire [qcs_pkg::SRC_W-1:0] wdat16  = wb_dat_i[qcs_pkg::SRC_W-1:0];
  wire [qcs_pkg::PH_W-1:0]  wmask8  = bmask[qcs_pkg::PH_W-1:0];
  wire [qcs_pkg::PH_W-1:0]  wdat8   = wb_dat_i[qcs_pkg::PH_W-1:0];
  wire [qcs_pkg::MODE_W-1:0] wmode  = wb_dat_i[qcs_pkg::MODE_W-1:0];

  // ==========================================================
  // mode presets
  logic [qcs_pkg::PH_W-1:0] pre_up;
  logic [qcs_pkg::PH_W-1:0] pre_dn;
  logic                     pre_ok;

  always_comb begin
    pre_ok = 1'b1;
    pre_up = up_src_r;
    pre_dn = dn_src_r;
    case (wmode)
      qcs_pkg::MODE_1: begin
        pre_up = qcs_pkg::UP_M1;
        pre_dn = qcs_pkg::DN_M1;
      end
      qcs_pkg::MODE_2_1: begin
        pre_up = qcs_pkg::UP_M2_1;
        pre_dn = qcs_pkg::DN_M2_1;
      end
      qcs_pkg::MODE_2_2: begin
        pre_up = qcs_pkg::UP_M2_2;
        pre_dn = qcs_pkg::DN_M2_2;
      end
      // 2-3 up both a edges b1
      // 2-3 down both a edges b0
      qcs_pkg::MODE_2_3: begin
        pre_up = qcs_pkg::UP_M2_3;
        pre_dn = qcs_pkg::DN_M2_3;
      end
      qcs_pkg::MODE_3_1: begin
        pre_up = qcs_pkg::UP_M3_1;
        pre_dn = qcs_pkg::DN_M3_1;
      end
      qcs_pkg::MODE_3_2: begin
        pre_up = qcs_pkg::UP_M3_2;
        pre_dn = qcs_pkg::DN_M3_2;
      end
      default: begin
        pre_ok = 1'b0;  // custom: keep sets
      end
    endcase
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r      <= qcs_pkg::MODE_RST;
      start_src_r <= qcs_pkg::SRC_RST;
      stop_src_r  <= qcs_pkg::SRC_RST;
      clear_src_r <= qcs_pkg::SRC_RST;
    end else begin
      if (wr_mode)
        mode_r <= wmode;
      if (wr_strt)
        start_src_r <= (start_src_r & ~wmask16) | (wdat16 & wmask16);
      if (wr_stop)
        stop_src_r <= (stop_src_r & ~wmask16) | (wdat16 & wmask16);
      if (wr_clr)
        clear_src_r <= (clear_src_r & ~wmask16) | (wdat16 & wmask16);
    end
  end

  // up/down sets have no trigger bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_src_r <= qcs_pkg::SRC_RST[qcs_pkg::PH_W-1:0];
      dn_src_r <= qcs_pkg::SRC_RST[qcs_pkg::PH_W-1:0];
    end else if (wr_mode & pre_ok) begin
      up_src_r <= pre_up;
      dn_src_r <= pre_dn;
    end else begin
      if (wr_up)
        up_src_r <= (up_src_r & ~wmask8) | (wdat8 & wmask8);
      if (wr_dn)
        dn_src_r <= (dn_src_r & ~wmask8) | (wdat8 & wmask8);
    end
  end

  // ==========================================================
  // run state: stop wins over start
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      QCS_IDLE: begin
        if ((start_hit | sw_start) & ~(stop_hit | sw_stop))
          state_nxt = QCS_RUN;
      end
      QCS_RUN: begin
        if (stop_hit | sw_stop)
          state_nxt = QCS_IDLE;
      end
      default: begin
        state_nxt = QCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      state_r <= QCS_IDLE;
    else
      state_r <= state_nxt;
  end

  // ==========================================================
  // counter next value: clear, bus write, then count
  wire running = (state_r == QCS_RUN);

  always_comb begin
    cnt_nxt = cnt_r;
    if (clear_hit | sw_clear)
      cnt_nxt = qcs_pkg::CNT_RST;
    else if (wr_cnt)
      cnt_nxt = (cnt_r & ~bmask) | (wb_dat_i & bmask);
    // no hit or both hits, no change
    else if (running & up_hit & ~dn_hit)
      cnt_nxt = cnt_r + 32'h0000_0001;
    else if (running & dn_hit & ~up_hit)
      cnt_nxt = cnt_r - 32'h0000_0001;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= qcs_pkg::CNT_RST;
      dir_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      if (running & (up_hit ^ dn_hit))
        dir_r <= dn_hit;
    end
  end

  // ==========================================================
  // read mux
  logic [31:0] rmux;

  always_comb begin
    rmux = 32'h0000_0000;
    case (wb_adr_i)
      qcs_pkg::OFS_MODE:   rmux[qcs_pkg::MODE_W-1:0] = mode_r;
      qcs_pkg::OFS_START:  rmux[qcs_pkg::SRC_W-1:0]  = start_src_r;
      qcs_pkg::OFS_STOP:   rmux[qcs_pkg::SRC_W-1:0]  = stop_src_r;
      qcs_pkg::OFS_CLEAR:  rmux[qcs_pkg::SRC_W-1:0]  = clear_src_r;
      qcs_pkg::OFS_UP:     rmux[qcs_pkg::PH_W-1:0]   = up_src_r;
      qcs_pkg::OFS_DOWN:   rmux[qcs_pkg::PH_W-1:0]   = dn_src_r;
      qcs_pkg::OFS_COUNT:  rmux = cnt_r;
      qcs_pkg::OFS_STATUS: begin
        rmux[qcs_pkg::STAT_RUN_BIT] = running;
        rmux[qcs_pkg::STAT_DIR_BIT] = dir_r;
      end
      default: rmux = 32'h0000_0000;  // ctrl and unmapped
    endcase
  end

  // ==========================================================
  // bus answer: one cycle after request, one-cycle ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      if (req & ~wb_we_i)
        rdat_r <= rmux;
    end
  end

  // ==========================================================
  // outputs
  logic        run_r;

  always_ff @(posedge clk_i) begin
    if (rst_i)
      run_r <= 1'b0;
    else
      run_r <= (state_nxt == QCS_RUN);
  end

  assign wb_ack_o   = ack_r;
  assign wb_dat_o   = rdat_r;
  assign count_o    = cnt_r;
  assign running_o  = run_r;
  assign dir_down_o = dir_r;

endmodule

/* File: tb/qcs_top_chk.sv */
/*
 * Port checker for qcs_top: bus handshake and counter stepping.
 * Assumes one clock, rst_i synchronous active high, bound below.
 */
`timescale 1ns/1ps

// ==========================================================
// checker
module qcs_top_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        phase_a_input_i,
  input wire logic        phase_b_input_i,
  input wire logic        ext_trigger_a_i,
  input wire logic        ext_trigger_b_i,
  input wire logic        ext_trigger_c_i,
  input wire logic        ext_trigger_d_i,
  input wire logic [31:0] count_o,
  input wire logic        running_o,
  input wire logic        dir_down_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // bus qualifiers
  wire logic wr_ack = wb_ack_o && wb_we_i;
  wire logic rd_ack = wb_ack_o && !wb_we_i;
  wire logic req_w  = wb_cyc_i && wb_stb_i;

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_latency: assert property (req_w && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req_w))
    else $error("ack without request");
  a_step_one: assert property (!wr_ack |->
    (count_o - $past(count_o)) inside {32'h0, 32'h1, 32'hffff_ffff})
    else $error("count moved by more than one");
  a_edge_cause: assert property (!wr_ack && count_o != $past(count_o) |->
    $past(phase_a_input_i, 3) != $past(phase_a_input_i, 4) ||
    $past(phase_b_input_i, 3) != $past(phase_b_input_i, 4))
    else $error("count moved without a phase edge");
  a_idle_hold: assert property (!wr_ack && !running_o && !$past(running_o)
    |-> $stable(count_o)) else $error("count moved while idle");
  a_dir_up: assert property (!wr_ack && count_o == $past(count_o) + 32'h1
    |-> !dir_down_o) else $error("up count flagged as down");
  a_dir_down: assert property (!wr_ack && count_o == $past(count_o) - 32'h1
    |-> dir_down_o) else $error("down count flagged as up");
  a_updn_no_trig: assert property (rd_ack && wb_adr_i inside {8'h14, 8'h18}
    |-> wb_dat_o[31:8] == 24'h0) else $error("count set holds trigger bits");
endmodule

bind qcs_top qcs_top_chk u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .phase_a_input_i(phase_a_input_i),
  .phase_b_input_i(phase_b_input_i), .ext_trigger_a_i(ext_trigger_a_i),
  .ext_trigger_b_i(ext_trigger_b_i), .ext_trigger_c_i(ext_trigger_c_i),
  .ext_trigger_d_i(ext_trigger_d_i), .count_o(count_o), .running_o(running_o),
  .dir_down_o(dir_down_o));

/* File: tb/qcs_enc_model.sv */
/*
 * Quadrature encoder model: moves one phase at a time.
 * Assumes the caller spaces steps by at least two clocks.
 */
`timescale 1ns/1ps

// ==========================================================
// encoder
module qcs_enc_model (
  input  wire logic clk_i,
  output logic      phase_a_o,
  output logic      phase_b_o
);
  // both phases idle low
  initial begin
    phase_a_o = 1'b0;
    phase_b_o = 1'b0;
  end

  // toggle one phase, then dwell gap cycles
  task automatic step(input int pin_b, input int gap);
    @(posedge clk_i);
    if (pin_b != 0) begin
      phase_b_o <= ~phase_b_o;
    end else begin
      phase_a_o <= ~phase_a_o;
    end
    repeat (gap) @(posedge clk_i);
  endtask
endmodule

/* File: tb/qcs_top_tb_top.sv */
/*
 * Self-checking bench for qcs_top against a counting model.
 * Assumes the encoder model and checker compiled before it.
 */
`timescale 1ns/1ps

// ==========================================================
// bench
module qcs_top_tb_top;
  logic        clk_i, rst_i, cyc, stb, we, run, mdir;
  logic [7:0]  adr, up, dn;
  logic [3:0]  sel, trg;
  logic [31:0] dat, rd, mcnt;
  wire logic   pa_w, pb_w, ack_w, run_w, dir_w;
  wire logic [31:0] dato_w, cnt_w;
  int          miscompares, compares;

  qcs_enc_model enc (.clk_i(clk_i), .phase_a_o(pa_w), .phase_b_o(pb_w));

  qcs_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dato_w),
    .wb_ack_o(ack_w), .phase_a_input_i(pa_w), .phase_b_input_i(pb_w),
    .ext_trigger_a_i(trg[0]), .ext_trigger_b_i(trg[1]), .ext_trigger_c_i(trg[2]),
    .ext_trigger_d_i(trg[3]), .count_o(cnt_w), .running_o(run_w), .dir_down_o(dir_w));

  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // verdict and end of run
  task automatic summarize();
    if (miscompares == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_w !== 1'b1 && n < 20);
    q = dato_w;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
    if (n >= 20) miscompares++;
  endtask

  // count change for one phase edge: pb pin b, nw new level, ot other phase
  function automatic int delta(int m, int pb, int nw, int ot);
    int i;
    i = pb * 4 + (nw != 0 ? 0 : 2) + ot;
    case (m)
      1: return ((pb != 0) ? nw == ot : nw != ot) ? 1 : -1;
      2: return (pb != 0 || nw != 0) ? 0 : (ot != 0 ? 1 : -1);
      3: return (pb != 0 || nw == 0) ? 0 : (ot != 0 ? 1 : -1);
      4: return (pb != 0) ? 0 : (ot != 0 ? 1 : -1);
      5: return (ot == 0 || nw != 0) ? 0 : (pb != 0 ? -1 : 1);
      6: return (ot == 0 || nw == 0) ? 0 : (pb != 0 ? -1 : 1);
      default: return int'(up[i]) - int'(dn[i]);
    endcase
  endfunction

  // one random phase or trigger edge, then compare with the model
  task automatic step(input int mc);
    int k, nw, ot, d;
    k = $urandom_range(0, 5);
    d = 0;
    if (k > 1) begin
      trg <= trg ^ 4'(1 << (k - 2));
      repeat (6) @(posedge clk_i);
    end else begin
      nw = (k != 0) ? int'(!pb_w) : int'(!pa_w);
      ot = (k != 0) ? int'(pa_w) : int'(pb_w);
      enc.step(k, 6 + $urandom_range(0, 3));
      if (run) d = delta(mc, k, nw, ot);
    end
    mcnt = mcnt + 32'(d);
    if (d != 0) mdir = (d < 0);
    chk(cnt_w, mcnt);
    chk({31'h0, dir_w}, {31'h0, mdir});
  endtask

  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
    dat = 32'h0; trg = 4'h0; up = 8'h00; dn = 8'h00;
    miscompares = 0; compares = 0; mcnt = 32'h0; mdir = 1'b0; run = 1'b0;
    void'($urandom(95));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(cnt_w, 32'h0);
    chk({30'h0, run_w, dir_w}, 32'h0);
    wb(1'b0, 8'h04, 32'h0, rd);
    chk(rd, 32'h0);
    wb(1'b0, 8'h14, 32'h0, rd);
    chk(rd, 32'h0);
    wb(1'b0, 8'h40, 32'h0, rd);
    chk(rd, 32'h0);
    mcnt = $urandom;
    wb(1'b1, 8'h1c, mcnt, rd);
    wb(1'b0, 8'h1c, 32'h0, rd);
    chk(rd, mcnt);
    mcnt = 32'hffff_ffff;
    wb(1'b1, 8'h1c, mcnt, rd);
    // every mode code, custom sets random
    for (int m = 1; m < 9; m++) begin
      wb(1'b1, 8'h04, 32'(m % 8), rd);
      if (m % 8 == 0 || m % 8 == 7) begin
        up = 8'($urandom);
        dn = 8'($urandom);
        wb(1'b1, 8'h14, {24'h0, up}, rd);
        wb(1'b1, 8'h18, {24'h0, dn}, rd);
      end
      wb(1'b1, 8'h00, (m == 1) ? 32'h1 : 32'h5, rd);
      run = 1'b1;
      if (m != 1) mcnt = 32'h0;
      repeat (24) step(m % 8);
    end
    // stopped counter ignores edges
    wb(1'b1, 8'h00, 32'h2, rd);
    run = 1'b0;
    repeat (8) step(1);
    wb(1'b0, 8'h1c, 32'h0, rd);
    chk(rd, mcnt);
    wb(1'b0, 8'h20, 32'h0, rd);
    chk(rd, {30'h0, mdir, 1'b0});
    // trigger a rise starts, trigger a fall stops, count untouched
    wb(1'b1, 8'h08, 32'h0000_0100, rd);
    wb(1'b1, 8'h0c, 32'h0000_0200, rd);
    wb(1'b0, 8'h0c, 32'h0, rd);
    chk(rd, 32'h0000_0200);
    trg <= trg & 4'he;
    repeat (6) @(posedge clk_i);
    chk({31'h0, run_w}, 32'h0);
    trg <= trg | 4'h1;
    repeat (6) @(posedge clk_i);
    chk({31'h0, run_w}, 32'h1);
    trg <= trg & 4'he;
    repeat (6) @(posedge clk_i);
    chk({31'h0, run_w}, 32'h0);
    chk(cnt_w, mcnt);
    summarize();
  end

  // hang guard, well beyond the expected run length
  initial begin
    #100000;
    miscompares++;
    summarize();
  end
endmodule
